// file: hw/nse_exec.sv
// Execution datapath for the nibble exchange instruction.
//
// Overview of operation
// RULE1 - Result high nibble is source low nibble; result low nibble is source high nibble.
// RULE2 - Takes an 8-bit file address, 0 to 255, and a one-bit destination select.
// RULE3 - Destination 0 writes the working register; destination 1 writes the file back.
// RULE4 - A source of 0x53 yields 0x35.
// RULE5 - One instruction cycle, one word, status flags untouched.
`timescale 1ns/1ps
module nse_exec
  import nse_pkg::*;
#(
  parameter int DATA_W = NSE_DATA_W,
  parameter int ADDR_W = NSE_ADDR_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic opValid,
  input wire logic [ADDR_W-1:0] opAddr,
  input wire logic opDest,
  input wire logic [DATA_W-1:0] fileRdData,
  input wire logic [7:0] statusIn,
  output logic [ADDR_W-1:0] fileAddr,
  output logic fileRdEn,
  output logic fileWrEn,
  output logic [DATA_W-1:0] fileWrData,
  output logic [DATA_W-1:0] workingRegister,
  output logic wregWrEn,
  output logic [7:0] statusOut,
  output logic busy,
  output logic done
);
  // ****************************************
  // Phase sequencer
  // ****************************************
  // The instruction occupies exactly one Q1..Q4 cycle; a new one may start only in Q1.
  nse_phase_t phase, next_phase;
  logic [ADDR_W-1:0] next_fileAddr;
  logic destReg, next_destReg;
  logic [DATA_W-1:0] srcLatch, next_srcLatch;
  logic [DATA_W-1:0] result, next_result;
  logic [DATA_W-1:0] next_workingRegister;
  logic [DATA_W-1:0] swapped;

  nse_swap_unit #(.DATA_W(DATA_W)) u_swap (
    .srcByte(srcLatch),
    .swappedByte(swapped)
  );

  always_comb begin
    next_phase = phase;
    next_fileAddr = fileAddr;
    next_destReg = destReg;
    next_srcLatch = srcLatch;
    next_result = result;
    next_workingRegister = workingRegister;
    unique case (phase)
      NSE_Q1: begin
        if (opValid) begin
          next_fileAddr = opAddr; // [RULE2]
          next_destReg = opDest; // [RULE2]
          next_phase = NSE_Q2;
        end
      end
      NSE_Q2: begin
        next_srcLatch = fileRdData;
        next_phase = NSE_Q3;
      end
      NSE_Q3: begin
        next_result = swapped; // [RULE1]
        next_phase = NSE_Q4;
      end
      NSE_Q4: begin
        if (destReg == NSE_DEST_WORKING_REGISTER) begin
          next_workingRegister = result; // [RULE3]
        end
        next_phase = NSE_Q1; // [RULE5]
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      phase <= NSE_Q1;
      fileAddr <= '0;
      destReg <= NSE_DEST_WORKING_REGISTER;
      srcLatch <= '0;
      result <= '0;
      workingRegister <= NSE_WORKING_REGISTER_RST;
    end else if (clkEn) begin
      phase <= next_phase;
      fileAddr <= next_fileAddr;
      destReg <= next_destReg;
      srcLatch <= next_srcLatch;
      result <= next_result;
      workingRegister <= next_workingRegister;
    end
  end

  // ****************************************
  // Strobes toward the data-memory file and working register, plus status, busy and done
  // ****************************************
  // Strobes are qualified by the clock enable so a frozen core never repeats a write.
  always_comb begin
    fileRdEn = clkEn && (phase == NSE_Q2);
    fileWrEn = clkEn && (phase == NSE_Q4) && (destReg == NSE_DEST_FILE); // [RULE3]
    wregWrEn = clkEn && (phase == NSE_Q4) && (destReg == NSE_DEST_WORKING_REGISTER); // [RULE3]
    fileWrData = result;
    statusOut = statusIn; // [RULE5]
    busy = (phase != NSE_Q1);
    done = clkEn && (phase == NSE_Q4);
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_swap_map;
    @(posedge clk) disable iff (reset)
      (clkEn && phase == NSE_Q3) |=> (result == {srcLatch[3:0], srcLatch[7:4]});
  endproperty
  a_swap_map: assert property (p_swap_map) else $error("nibble swap wrong"); // [RULE1]

  property p_addr_take;
    @(posedge clk) disable iff (reset)
      (clkEn && phase == NSE_Q1 && opValid) |=> (fileAddr == $past(opAddr));
  endproperty
  a_addr_take: assert property (p_addr_take) else $error("address not taken"); // [RULE2]

  property p_dest_file;
    @(posedge clk) disable iff (reset)
      (fileWrEn) |-> (destReg == NSE_DEST_FILE && fileWrData == result && !wregWrEn);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file write misrouted"); // [RULE3]

  property p_dest_working_register;
    @(posedge clk) disable iff (reset)
      (wregWrEn) |=> (workingRegister == $past(result));
  endproperty
  a_dest_working_register: assert property (p_dest_working_register) else $error("working register not written"); // [RULE3]

  property p_example;
    @(posedge clk) disable iff (reset)
      (clkEn && phase == NSE_Q3 && srcLatch == NSE_EXAMPLE_SRC) |=> (result == NSE_EXAMPLE_RES);
  endproperty
  a_example: assert property (p_example) else $error("0x53 did not give 0x35"); // [RULE4]

  property p_one_cycle;
    @(posedge clk) disable iff (reset)
      (clkEn && phase == NSE_Q1 && opValid) ##1 clkEn ##1 clkEn ##1 clkEn |=> (phase == NSE_Q1);
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("operation overran a cycle"); // [RULE5]

  property p_status_kept;
    @(posedge clk) disable iff (reset) statusOut == statusIn;
  endproperty
  a_status_kept: assert property (p_status_kept) else $error("status altered"); // [RULE5]

  property p_working_register_hold;
    @(posedge clk) disable iff (reset)
      (!wregWrEn) |=> (workingRegister == $past(workingRegister));
  endproperty
  a_working_register_hold: assert property (p_working_register_hold) else $error("working register changed"); // [RULE3]

  // ****************************************
  // Freeze and refusal checks
  // ****************************************
  // A stuck or glitching clock enable would otherwise hide a repeated write, so it is guarded.
  property p_rd_take;
    @(posedge clk) disable iff (reset)
      (fileRdEn) |-> (phase == NSE_Q2 && busy);
  endproperty
  a_rd_take: assert property (p_rd_take) else $error("read strobe outside Q2"); // [RULE2]

  property p_src_capture;
    @(posedge clk) disable iff (reset)
      (fileRdEn) |=> (srcLatch == $past(fileRdData));
  endproperty
  a_src_capture: assert property (p_src_capture) else $error("source byte not captured"); // [RULE1]

  property p_freeze;
    @(posedge clk) disable iff (reset)
      (!clkEn) |=> (phase == $past(phase) && result == $past(result));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen"); // [RULE5]

  property p_strobe_gate;
    @(posedge clk) disable iff (reset)
      (!clkEn) |-> (!fileRdEn && !fileWrEn && !wregWrEn && !done);
  endproperty
  a_strobe_gate: assert property (p_strobe_gate) else $error("strobe while frozen"); // [RULE5]

  property p_wr_once;
    @(posedge clk) disable iff (reset)
      (fileWrEn) |=> (!fileWrEn);
  endproperty
  a_wr_once: assert property (p_wr_once) else $error("file written twice"); // [RULE3]

  property p_refuse;
    @(posedge clk) disable iff (reset)
      (busy) |=> (fileAddr == $past(fileAddr));
  endproperty
  a_refuse: assert property (p_refuse) else $error("request taken while busy"); // [RULE2]

  property p_idle_quiet;
    @(posedge clk) disable iff (reset)
      (!busy) |-> (!fileRdEn && !fileWrEn && !wregWrEn);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("strobe while idle"); // [RULE5]

  property p_wrdata_hold;
    @(posedge clk) disable iff (reset)
      (clkEn && phase == NSE_Q4) |=> (fileWrData == $past(fileWrData));
  endproperty
  a_wrdata_hold: assert property (p_wrdata_hold) else $error("result not held"); // [RULE3]

  property p_done_pair;
    @(posedge clk) disable iff (reset)
      (done) |-> (fileWrEn || wregWrEn);
  endproperty
  a_done_pair: assert property (p_done_pair) else $error("done without a write"); // [RULE3]

  c_file_write: cover property (@(posedge clk) disable iff (reset) fileWrEn);
  c_freeze: cover property (@(posedge clk) disable iff (reset) busy && !clkEn);
  c_working_register_write: cover property (@(posedge clk) disable iff (reset) wregWrEn);
  c_example: cover property (@(posedge clk) disable iff (reset) srcLatch == NSE_EXAMPLE_SRC);
  c_back_to_back: cover property (@(posedge clk) disable iff (reset) done ##1 (opValid && clkEn));
endmodule

// file: hw/nse_pkg.sv
// Package with constants for the nibble exchange execution datapath.
package nse_pkg;
  // ****************************************
  // Widths and encodings
  // ****************************************
  localparam int NSE_DATA_W = 8;
  localparam int NSE_ADDR_W = 8;
  localparam int NSE_LO_MSB = 3;
  localparam int NSE_HI_LSB = 4;
  localparam int NSE_HI_MSB = 7;
  localparam logic NSE_DEST_WORKING_REGISTER = 1'b0;
  localparam logic NSE_DEST_FILE = 1'b1;
  localparam logic [7:0] NSE_WORKING_REGISTER_RST = 8'h00;
  localparam logic [7:0] NSE_EXAMPLE_SRC = 8'h53;
  localparam logic [7:0] NSE_EXAMPLE_RES = 8'h35;
  localparam logic [1:0] NSE_PHASE_RST = 2'h0;
  // ****************************************
  // Instruction cycle phases
  // ****************************************
  typedef enum logic [1:0] {NSE_Q1, NSE_Q2, NSE_Q3, NSE_Q4} nse_phase_t;
endpackage

// file: hw/nse_swap_unit.sv
// Combinational nibble exchange of one byte.
`timescale 1ns/1ps
module nse_swap_unit
  import nse_pkg::*;
#(
  parameter int DATA_W = NSE_DATA_W
) (
  input wire logic [DATA_W-1:0] srcByte,
  output logic [DATA_W-1:0] swappedByte
);
  always_comb begin
    swappedByte = {srcByte[NSE_LO_MSB:0], srcByte[NSE_HI_MSB:NSE_HI_LSB]}; // [RULE1]
  end
endmodule

// file: tb/nse_exec_tb_top.sv
// Self-checking bench for the nibble exchange execution datapath.
`timescale 1ns/1ps
module nse_exec_tb_top
  import nse_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  logic opValid = 1'b0;
  logic opDest = 1'b0;
  logic [7:0] opAddr = 8'h00;
  logic [7:0] fileRdData = 8'h00;
  logic [7:0] statusIn = 8'h00;
  logic [7:0] fileAddr, fileWrData, workingRegister, statusOut;
  logic fileRdEn, fileWrEn, wregWrEn, busy, done;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [15:0] lfsr = 16'd1062;
  logic [7:0] expWreg = NSE_WORKING_REGISTER_RST;
  logic [7:0] prevA = 8'h00;
  logic [7:0] expQ[$];

  nse_exec i_dut (.clk(clk), .reset(reset), .clkEn(clkEn), .opValid(opValid),
    .opAddr(opAddr), .opDest(opDest), .fileRdData(fileRdData), .statusIn(statusIn),
    .fileAddr(fileAddr), .fileRdEn(fileRdEn), .fileWrEn(fileWrEn),
    .fileWrData(fileWrData), .workingRegister(workingRegister), .wregWrEn(wregWrEn),
    .statusOut(statusOut), .busy(busy), .done(done));

  initial begin
    forever #2 clk = ~clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One operation; the idle checks of the previous one fall in this one's Q1.
  // The request is left raised through Q2..Q4 so that a refused request is exercised.
  task automatic runOp(input logic go, input logic [7:0] a, input logic [7:0] s,
    input logic d);
    logic [7:0] r;
    r = 8'((s % 16) * 16 + s / 16);
    @(posedge clk);
    opValid <= go;
    opAddr <= a;
    opDest <= d;
    statusIn <= lfsr[7:0];
    #1;
    chk("busy", 8'h00, 8'(busy));
    chk("working_register", expWreg, workingRegister);
    chk("fileAddr", prevA, fileAddr);
    if (!go) begin
      return;
    end
    expQ.push_back(r);
    @(posedge clk);
    opAddr <= ~a;
    opDest <= ~d;
    fileRdData <= s;
    #1;
    chk("rdEn", 8'h01, 8'(fileRdEn));
    chk("fileAddr", a, fileAddr);
    @(posedge clk);
    fileRdData <= ~s;
    @(posedge clk);
    #1;
    chk("result", expQ.pop_front(), fileWrData);
    chk("fileWrEn", 8'(d), 8'(fileWrEn));
    chk("wregWrEn", 8'(!d), 8'(wregWrEn));
    chk("done", 8'h01, 8'(done));
    chk("status", statusIn, statusOut);
    prevA = a;
    if (!d) begin
      expWreg = r;
    end
  endtask

  // One file-destination operation with the clock enable dropped for one cycle in Q2.
  task automatic runFrozen(input logic [7:0] a, input logic [7:0] s);
    logic [7:0] r;
    r = 8'((s % 16) * 16 + s / 16);
    @(posedge clk);
    opValid <= 1'b1;
    opAddr <= a;
    opDest <= 1'b1;
    @(posedge clk);
    opValid <= 1'b0;
    clkEn <= 1'b0;
    fileRdData <= s;
    #1;
    chk("frozenRdEn", 8'h00, 8'(fileRdEn));
    chk("frozenBusy", 8'h01, 8'(busy));
    @(posedge clk);
    clkEn <= 1'b1;
    #1;
    chk("rdEn", 8'h01, 8'(fileRdEn));
    chk("fileAddr", a, fileAddr);
    @(posedge clk);
    @(posedge clk);
    #1;
    chk("result", r, fileWrData);
    chk("fileWrEn", 8'h01, 8'(fileWrEn));
    prevA = a;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    runOp(1'b1, 8'h10, NSE_EXAMPLE_SRC, 1'b0);
    runOp(1'b1, 8'hff, NSE_EXAMPLE_SRC, 1'b1);
    runOp(1'b1, 8'h00, 8'ha5, 1'b0);
    for (int i = 0; i < 40; i++) begin
      lfsr = step(lfsr);
      runOp(1'b1, lfsr[7:0], lfsr[15:8], lfsr[3]);
    end
    runFrozen(8'h3c, NSE_EXAMPLE_SRC);
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    expWreg = NSE_WORKING_REGISTER_RST;
    prevA = 8'h00;
    runOp(1'b1, 8'h77, 8'h0f, 1'b0);
    runOp(1'b0, 8'h00, 8'h00, 1'b0);
    summarize();
  end
endmodule
